// ---- hdl/ttp_top.sv ----
// ttp_top: triple timer unit with waveform outputs, prescaling and edge demodulation
// assumes an apb master on pclk; demod_in is an asynchronous pin
`timescale 1ns/100ps
// Behaviour
// - timers advance once every four clocks at most
// - power save mode slows the timer count rate
// - each timer has its own software mode word register
// - dual-limit timers each hold limit a and limit b
// - waveform output high through limit a phase, low through limit b
// - counters are sixteen bits and readable at any time
// - prescaler timer has only one limit, no waveform pin and no prescaling, otherwise alike
// - interrupt request when count reaches programmed maximum
// - demod enable bit in system config switches input handling
// - demod raises separate requests on falling and rising edges
module ttp_top #(
  parameter int unsigned W = ttp_pkg::CNT_W // counter width
)
(
  input wire logic pclk, // apb clock, 50 MHz
  input wire logic presetn, // async reset, low active
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic demod_in, // pulse input, asynchronous
  output logic wave0, // first dual-limit timer waveform
  output logic wave1, // second dual-limit timer waveform
  output logic irq // level interrupt
);
  typedef struct packed
  {
    logic [ttp_pkg::MODE_W-1:0] mode0;
    logic [ttp_pkg::MODE_W-1:0] mode1;
    logic [ttp_pkg::MODE_W-1:0] mode2;
    logic [W-1:0] lima0;
    logic [W-1:0] limb0;
    logic [W-1:0] lima1;
    logic [W-1:0] limb1;
    logic [W-1:0] lima2;
    logic [ttp_pkg::SYSCFG_W-1:0] syscfg;
    logic [ttp_pkg::ST_W-1:0] stat;
    logic [ttp_pkg::ST_W-1:0] mask;
    logic [1:0] sync;
    logic demod_prev;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic wave0;
    logic wave1;
    logic irq;
  } ttp_top_st_t;
  ttp_top_st_t s_q;
  ttp_top_st_t s_d;
  logic tick;
  logic [W-1:0] cnt0;
  logic [W-1:0] cnt1;
  logic [W-1:0] cnt2;
  logic w0;
  logic w1;
  logic d0;
  logic d1;
  logic d2;
  logic acc;
  logic wr;
  logic [ttp_pkg::ST_W-1:0] ev;
  logic [ttp_pkg::ST_W-1:0] clr;
  logic [31:0] rd;
  logic hit;
  logic rise;
  logic fall;

  ttp_tick u_tick
  (
    .pclk(pclk),
    .presetn(presetn),
    .psave(s_q.syscfg[ttp_pkg::SB_PSAVE]),
    .psdiv(s_q.syscfg[ttp_pkg::SB_PSDIV +: ttp_pkg::SB_PSDIV_W]),
    .tick(tick)
  );

  ttp_chan #(.W(W), .DUAL(1'b1)) u_t0
  (
    .pclk(pclk),
    .presetn(presetn),
    .mode(s_q.mode0),
    .lim_a(s_q.lima0),
    .lim_b(s_q.limb0),
    .base_tick(tick),
    .pre_tick(d2),
    .count(cnt0),
    .wave(w0),
    .done(d0)
  );

  ttp_chan #(.W(W), .DUAL(1'b1)) u_t1
  (
    .pclk(pclk),
    .presetn(presetn),
    .mode(s_q.mode1),
    .lim_a(s_q.lima1),
    .lim_b(s_q.limb1),
    .base_tick(tick),
    .pre_tick(d2),
    .count(cnt1),
    .wave(w1),
    .done(d1)
  );

  // prescaler timer ignores its own prescale bit
  ttp_chan #(.W(W), .DUAL(1'b0)) u_t2
  (
    .pclk(pclk),
    .presetn(presetn),
    .mode(s_q.mode2 & ~(ttp_pkg::MODE_W'(1) << ttp_pkg::MB_PRE)),
    .lim_a(s_q.lima2),
    .lim_b(s_q.lima2),
    .base_tick(tick),
    .pre_tick(1'b0),
    .count(cnt2),
    .wave(),
    .done(d2)
  );

  always_comb
  begin
    s_d = s_q;
    acc = psel && penable && s_q.pready;
    wr = acc && pwrite;
    // second stage only is examined for edges
    s_d.sync = {s_q.sync[0], demod_in};
    s_d.demod_prev = s_q.sync[1];
    rise = s_q.sync[1] && !s_q.demod_prev;
    fall = !s_q.sync[1] && s_q.demod_prev;
    ev = '0;
    ev[ttp_pkg::ST_T0] = d0 && s_q.mode0[ttp_pkg::MB_IE];
    ev[ttp_pkg::ST_T1] = d1 && s_q.mode1[ttp_pkg::MB_IE];
    ev[ttp_pkg::ST_T2] = d2 && s_q.mode2[ttp_pkg::MB_IE];
    // edges only count once demod is on; handlers must already be set
    ev[ttp_pkg::ST_FALL] = fall && s_q.syscfg[ttp_pkg::SB_DEMOD];
    ev[ttp_pkg::ST_RISE] = rise && s_q.syscfg[ttp_pkg::SB_DEMOD];
    hit = 1'b1;
    rd = ttp_pkg::RESET_WORD;
    case (paddr)
      ttp_pkg::OFF_CTRL0: rd = 32'(s_q.mode0);
      ttp_pkg::OFF_LIMA0: rd = 32'(s_q.lima0);
      ttp_pkg::OFF_LIMB0: rd = 32'(s_q.limb0);
      ttp_pkg::OFF_CNT0: rd = 32'(cnt0);
      ttp_pkg::OFF_CTRL1: rd = 32'(s_q.mode1);
      ttp_pkg::OFF_LIMA1: rd = 32'(s_q.lima1);
      ttp_pkg::OFF_LIMB1: rd = 32'(s_q.limb1);
      ttp_pkg::OFF_CNT1: rd = 32'(cnt1);
      ttp_pkg::OFF_CTRL2: rd = 32'(s_q.mode2);
      ttp_pkg::OFF_LIMA2: rd = 32'(s_q.lima2);
      ttp_pkg::OFF_CNT2: rd = 32'(cnt2);
      ttp_pkg::OFF_SYSCFG: rd = 32'(s_q.syscfg);
      ttp_pkg::OFF_STAT: rd = 32'(s_q.stat);
      ttp_pkg::OFF_MASK: rd = 32'(s_q.mask);
      ttp_pkg::OFF_OUT: rd = 32'({s_q.sync[1], s_q.wave1, s_q.wave0});
      default: hit = 1'b0;
    endcase
    clr = '0;
    if (wr && hit)
    begin
      case (paddr)
        ttp_pkg::OFF_CTRL0: s_d.mode0 = pwdata[ttp_pkg::MODE_W-1:0];
        ttp_pkg::OFF_LIMA0: s_d.lima0 = pwdata[W-1:0];
        ttp_pkg::OFF_LIMB0: s_d.limb0 = pwdata[W-1:0];
        ttp_pkg::OFF_CTRL1: s_d.mode1 = pwdata[ttp_pkg::MODE_W-1:0];
        ttp_pkg::OFF_LIMA1: s_d.lima1 = pwdata[W-1:0];
        ttp_pkg::OFF_LIMB1: s_d.limb1 = pwdata[W-1:0];
        ttp_pkg::OFF_CTRL2: s_d.mode2 = pwdata[ttp_pkg::MODE_W-1:0];
        ttp_pkg::OFF_LIMA2: s_d.lima2 = pwdata[W-1:0];
        ttp_pkg::OFF_SYSCFG: s_d.syscfg = pwdata[ttp_pkg::SYSCFG_W-1:0];
        ttp_pkg::OFF_STAT: clr = pwdata[ttp_pkg::ST_W-1:0];
        ttp_pkg::OFF_MASK: s_d.mask = pwdata[ttp_pkg::ST_W-1:0];
        default: clr = '0;
      endcase
    end
    // a new event beats a clear in the same cycle
    s_d.stat = (s_q.stat & ~clr) | ev;
    // one wait state: ready rises in the second access cycle, drops after
    s_d.pready = psel && penable && !s_q.pready;
    s_d.pslverr = psel && penable && !s_q.pready && !hit;
    s_d.prdata = (psel && penable && !s_q.pready && !pwrite) ? rd : s_q.prdata;
    s_d.wave0 = w0;
    s_d.wave1 = w1;
    s_d.irq = |(s_d.stat & s_d.mask);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign wave0 = s_q.wave0;
  assign wave1 = s_q.wave1;
  assign irq = s_q.irq;
endmodule : ttp_top

// ---- hdl/ttp_pkg.sv ----
// ttp_pkg: register map, field positions and reset values of the triple timer unit
// assumes a 32-bit apb slave, one aligned word per register
package ttp_pkg;
  localparam int unsigned CNT_W = 16;
  localparam logic [7:0] OFF_CTRL0 = 8'h00;
  localparam logic [7:0] OFF_LIMA0 = 8'h04;
  localparam logic [7:0] OFF_LIMB0 = 8'h08;
  localparam logic [7:0] OFF_CNT0 = 8'h0C;
  localparam logic [7:0] OFF_CTRL1 = 8'h10;
  localparam logic [7:0] OFF_LIMA1 = 8'h14;
  localparam logic [7:0] OFF_LIMB1 = 8'h18;
  localparam logic [7:0] OFF_CNT1 = 8'h1C;
  localparam logic [7:0] OFF_CTRL2 = 8'h20;
  localparam logic [7:0] OFF_LIMA2 = 8'h24;
  localparam logic [7:0] OFF_CNT2 = 8'h2C;
  localparam logic [7:0] OFF_SYSCFG = 8'h30;
  localparam logic [7:0] OFF_STAT = 8'h34;
  localparam logic [7:0] OFF_MASK = 8'h38;
  localparam logic [7:0] OFF_OUT = 8'h3C;
  // mode word bits
  localparam int unsigned MB_EN = 0;
  localparam int unsigned MB_CONT = 1;
  localparam int unsigned MB_ALT = 2;
  localparam int unsigned MB_PRE = 3;
  localparam int unsigned MB_IE = 4;
  localparam int unsigned MODE_W = 5;
  // system config bits
  localparam int unsigned SB_DEMOD = 0;
  localparam int unsigned SB_PSAVE = 1;
  localparam int unsigned SB_PSDIV = 2;
  localparam int unsigned SB_PSDIV_W = 3;
  localparam int unsigned SYSCFG_W = 5;
  // status bits
  localparam int unsigned ST_T0 = 0;
  localparam int unsigned ST_T1 = 1;
  localparam int unsigned ST_T2 = 2;
  localparam int unsigned ST_FALL = 3;
  localparam int unsigned ST_RISE = 4;
  localparam int unsigned ST_W = 5;
  localparam logic [1:0] TICK_DIV = 2'h3;
  localparam logic [31:0] RESET_WORD = 32'h00000000;
endpackage : ttp_pkg

// ---- hdl/ttp_tick.sv ----
// ttp_tick: count-enable source, one pulse per four clocks, slower in power save
// assumes power-save controls come from registers on the same clock
`timescale 1ns/100ps
module ttp_tick
(
  input wire logic pclk, // apb clock
  input wire logic presetn, // async reset, low active
  input wire logic psave, // power save mode selected
  input wire logic [ttp_pkg::SB_PSDIV_W-1:0] psdiv, // power save clock divide, log2
  output logic tick // one-cycle count enable
);
  typedef struct packed
  {
    logic [1:0] quarter;
    logic [7:0] slow;
    logic tick;
  } ttp_tick_st_t;
  ttp_tick_st_t s_q;
  ttp_tick_st_t s_d;
  logic [7:0] slow_mask;
  always_comb
  begin
    s_d = s_q;
    // low psdiv bits of the slow counter must be zero for a tick
    slow_mask = 8'((16'h0001 << psdiv) - 16'h0001);
    s_d.quarter = s_q.quarter + 2'h1;
    s_d.tick = 1'b0;
    if (s_q.quarter == ttp_pkg::TICK_DIV)
    begin
      // power save stretches the quarter-rate tick by 2^psdiv
      if (!psave || ((s_q.slow & slow_mask) == 8'h00))
        s_d.tick = 1'b1;
      s_d.slow = s_q.slow + 8'h01;
    end
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_q <= '0;
    else
      s_q <= s_d;
  end
  assign tick = s_q.tick;
endmodule : ttp_tick

// ---- hdl/ttp_chan.sv ----
// ttp_chan: one 16-bit timer with optional second limit and waveform output
// assumes a count enable pulse and limits from registers on the same clock
`timescale 1ns/100ps
module ttp_chan #(
  parameter int unsigned W = 16, // counter width
  parameter bit DUAL = 1'b1 // second limit present
)
(
  input wire logic pclk, // apb clock
  input wire logic presetn, // async reset, low active
  input wire logic [ttp_pkg::MODE_W-1:0] mode, // mode word
  input wire logic [W-1:0] lim_a, // limit a
  input wire logic [W-1:0] lim_b, // limit b
  input wire logic base_tick, // quarter-rate enable
  input wire logic pre_tick, // prescaler timer terminal pulse
  output logic [W-1:0] count, // current count
  output logic wave, // waveform output
  output logic done // one-cycle full-count pulse
);
  typedef struct packed
  {
    logic [W-1:0] cnt;
    logic phase_b;
    logic wave;
    logic done;
    logic stop;
  } ttp_chan_st_t;
  ttp_chan_st_t s_q;
  ttp_chan_st_t s_d;
  logic step;
  logic alt;
  logic [W-1:0] lim;
  always_comb
  begin
    s_d = s_q;
    s_d.done = 1'b0;
    alt = DUAL && mode[ttp_pkg::MB_ALT];
    step = mode[ttp_pkg::MB_PRE] ? pre_tick : base_tick;
    lim = (alt && s_q.phase_b) ? lim_b : lim_a;
    if (!mode[ttp_pkg::MB_EN])
    begin
      s_d.cnt = '0;
      s_d.phase_b = 1'b0;
      s_d.wave = 1'b1;
      s_d.stop = 1'b0;
    end
    else if (step && !s_q.stop)
    begin
      if (s_q.cnt >= lim)
      begin
        s_d.cnt = '0;
        s_d.done = 1'b1;
        if (alt)
        begin
          s_d.phase_b = !s_q.phase_b;
          s_d.wave = s_q.phase_b;
        end
        else
          s_d.wave = !s_q.wave;
        if (!mode[ttp_pkg::MB_CONT] && (!alt || s_q.phase_b))
        begin
          // single shot holds and stays quiet; only a disable rearms it
          s_d.cnt = s_q.cnt;
          s_d.stop = 1'b1;
        end
      end
      else
        s_d.cnt = s_q.cnt + W'(1);
    end
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_q <= '{cnt: '0, phase_b: 1'b0, wave: 1'b1, done: 1'b0, stop: 1'b0};
    else
      s_q <= s_d;
  end
  assign count = s_q.cnt;
  assign wave = s_q.wave;
  assign done = s_q.done;
endmodule : ttp_chan

// ---- verif/ttp_chk.sv ----
// ttp_chk: port-level assertions for the triple timer unit
// assumes it is bound onto ttp_top, one pclk domain
`timescale 1ns/100ps
module ttp_chk #(
  parameter int unsigned W = 16 // counter width
)
(
  input wire logic pclk, // clock
  input wire logic presetn, // reset, low active
  input wire logic psel, // select
  input wire logic penable, // enable
  input wire logic pwrite, // direction
  input wire logic [7:0] paddr, // address
  input wire logic [31:0] prdata, // read data
  input wire logic pready, // ready
  input wire logic pslverr, // error
  input wire logic wave0, // waveform 0
  input wire logic wave1, // waveform 1
  input wire logic irq // interrupt
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire logic acc = psel && penable && !pready;
  logic [2:0] wr_age;
  // a mode write reaches the wave pins a few cycles late and may shorten one gap
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      wr_age <= 3'h7;
    else if (pready && pwrite)
      wr_age <= 3'h0;
    else if (wr_age != 3'h7)
      wr_age <= wr_age + 3'h1;
  end
  property p_ans; acc |=> pready; endproperty
  a_ans: assert property (p_ans) else $error("no ready after access");
  property p_one; pready |=> !pready; endproperty
  a_one: assert property (p_one) else $error("ready longer than one cycle");
  property p_err_hi; pready && paddr > ttp_pkg::OFF_OUT |-> pslverr; endproperty
  a_err_hi: assert property (p_err_hi) else $error("unmapped access not refused");
  property p_err_ok; pready && paddr <= ttp_pkg::OFF_OUT && paddr[1:0] == 2'h0 && paddr != 8'h28 |-> !pslverr;
  endproperty
  a_err_ok: assert property (p_err_ok) else $error("mapped access refused");
  property p_cnt; pready && !pwrite && paddr == ttp_pkg::OFF_CNT0 |-> prdata[31:W] == '0; endproperty
  a_cnt: assert property (p_cnt) else $error("count wider than counter");
  // irq only drops through a software write to status or mask
  property p_irq; $fell(irq) |-> (pwrite && pready) || $past(pwrite && pready) || $past(pwrite && pready, 2);
  endproperty
  a_irq: assert property (p_irq) else $error("irq fell without a write");
  property p_gap0; $changed(wave0) |=> (!$changed(wave0) || wr_age < 3'h5)[*3]; endproperty
  a_gap0: assert property (p_gap0) else $error("wave0 moved faster than tick");
  property p_gap1; $changed(wave1) |=> (!$changed(wave1) || wr_age < 3'h5)[*3]; endproperty
  a_gap1: assert property (p_gap1) else $error("wave1 moved faster than tick");
  c_err: cover property (pslverr);
  c_irq: cover property ($rose(irq));
  c_wave: cover property ($fell(wave0));
endmodule : ttp_chk
bind ttp_top ttp_chk #(.W(W)) ttp_chk_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .wave0(wave0),
  .wave1(wave1), .irq(irq));

// ---- verif/tb.sv ----
// tb: directed apb tests of the triple timer unit
// assumes ttp_top with default width and the bound checker
`timescale 1ns/100ps
module tb;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, demod_in = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000, prdata, q;
  logic pready, pslverr, wave0, wave1, irq, e;
  int n_errors = 0, num_checks = 0, hi, lo, n;
  always #10 pclk = ~pclk;
  ttp_top ttp_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .demod_in(demod_in), .wave0(wave0), .wave1(wave1), .irq(irq));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // one edge of idle before setup, so two calls never drive psel in one step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h00000000);
    chk(q, exp);
  endtask : rd
  // cycles that wave0 spends at lvl, counted from now if already at lvl, else from the next entry into lvl
  task automatic span(input logic lvl, output int k);
    while (wave0 !== lvl)
      @(posedge pclk);
    k = 0;
    while (wave0 === lvl)
    begin
      @(posedge pclk);
      k++;
    end
  endtask : span
  task automatic close_out();
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : close_out
  initial
  begin
    #80000;
    n_errors++;
    close_out();
  end
  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd(ttp_pkg::OFF_CTRL0, 32'h00000000);
    apb(1'b0, 8'h40, 32'h00000000);
    chk({q[30:0], e}, 32'h00000001);
    wr(ttp_pkg::OFF_LIMA0, 32'h00000003);
    wr(ttp_pkg::OFF_LIMB0, 32'h00000001);
    rd(ttp_pkg::OFF_LIMA0, 32'h00000003);
    wr(ttp_pkg::OFF_CTRL0, 32'h00000007);
    span(1'b1, n);
    span(1'b0, lo);
    span(1'b1, hi);
    chk(lo, 8);
    chk(hi, 16);
    span(1'b0, lo);
    chk(lo, 8);
    apb(1'b0, ttp_pkg::OFF_CNT0, 32'h00000000);
    chk({31'h0, q <= 32'h00000003}, 32'h00000001);
    wr(ttp_pkg::OFF_SYSCFG, 32'h00000006);
    span(1'b0, n);
    span(1'b1, hi);
    // divide log2 of one doubles every phase
    chk(hi, 32);
    wr(ttp_pkg::OFF_SYSCFG, 32'h00000000);
    wr(ttp_pkg::OFF_LIMA2, 32'h00000001);
    wr(ttp_pkg::OFF_CTRL2, 32'h00000003);
    wr(ttp_pkg::OFF_LIMA0, 32'h00000000);
    wr(ttp_pkg::OFF_LIMB0, 32'h00000000);
    wr(ttp_pkg::OFF_CTRL0, 32'h0000000F);
    span(1'b0, n);
    span(1'b1, hi);
    span(1'b0, lo);
    chk(hi, 8);
    chk(lo, 8);
    wr(ttp_pkg::OFF_LIMA1, 32'h00000002);
    wr(ttp_pkg::OFF_CTRL1, 32'h00000011);
    repeat (20) @(posedge pclk);
    chk({31'h0, irq}, 32'h00000000);
    // single shot toggles its wave once and holds the count at the limit
    chk({31'h0, wave1}, 32'h00000000);
    rd(ttp_pkg::OFF_CNT1, 32'h00000002);
    rd(ttp_pkg::OFF_STAT, 32'h00000002);
    wr(ttp_pkg::OFF_MASK, 32'h00000002);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h00000001);
    wr(ttp_pkg::OFF_STAT, 32'h00000002);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h00000000);
    demod_in <= 1'b1;
    repeat (8) @(posedge pclk);
    rd(ttp_pkg::OFF_STAT, 32'h00000000);
    // edge handlers unmasked before demod is switched on
    wr(ttp_pkg::OFF_MASK, 32'h00000018);
    wr(ttp_pkg::OFF_SYSCFG, 32'h00000001);
    demod_in <= 1'b0;
    repeat (8) @(posedge pclk);
    rd(ttp_pkg::OFF_STAT, 32'h00000008);
    demod_in <= 1'b1;
    repeat (8) @(posedge pclk);
    rd(ttp_pkg::OFF_STAT, 32'h00000018);
    chk({31'h0, irq}, 32'h00000001);
    close_out();
  end
endmodule : tb
